//--- include/pldhk_defines.svh
// Constants for the programmable logic housekeeping block
`ifndef PLDHK_DEFINES_SVH
`define PLDHK_DEFINES_SVH
`define PLDHK_CLK_PERIOD_NS 5
`define PLDHK_CLEAR_TYP_NS 600
`define PLDHK_CLEAR_MAX_NS 1000
`define PLDHK_CLEAR_CYCLES (`PLDHK_CLEAR_MAX_NS / `PLDHK_CLK_PERIOD_NS)
`define PLDHK_NUM_IN 12
`define PLDHK_NUM_MC 10
`define PLDHK_SIG_BITS 64
`define PLDHK_CNT_BITS 8
`define PLDHK_MC_RESET 10'h000
`define PLDHK_SIG_RESET 64'h0000_0000_0000_0000
`endif

//--- include/pldhk_pkg.sv
// Types for the programmable logic housekeeping block
`include "pldhk_defines.svh"
package pldhk_pkg;
   typedef logic [`PLDHK_NUM_MC-1:0] pldhk_mc_t;
   typedef logic [`PLDHK_NUM_IN-1:0] pldhk_in_t;
   typedef enum logic [0:0] {
      PLDHK_CLEARING = 1'b1,
      PLDHK_RUN = 1'b0
   } pldhk_phase_t;
   typedef struct packed {
      pldhk_phase_t phase;
      logic [`PLDHK_CNT_BITS-1:0] cnt;
      pldhk_mc_t mc;
      pldhk_mc_t outv;
      pldhk_mc_t oe_b;
      pldhk_in_t in_keep;
      pldhk_mc_t io_keep;
      logic fuse;
      logic [`PLDHK_SIG_BITS-1:0] sig;
      logic [2*`PLDHK_NUM_MC-1:0] vdata;
      logic vvalid;
      logic vrefused;
      logic prefused;
      logic pdone;
   } pldhk_state_t;
endpackage

//--- hdl/pldhk_top.sv
// Power-up clear, preload, security, signature and pin keepers of a small PLD
// How it works
// - Supply reaching threshold clears every macrocell register low after a short delay.
// - After clearing, each output shows the level its polarity setting gives.
// - Programmer may force any chosen high or low value into each register.
// - A 64-bit user signature stays readable always, even once secured.
// - Once the security fuse is set, verify and preload are refused.
// - Undriven input and I/O pins hold their last driven level weakly.
// - Twelve inputs, ten macrocells, each registered or combinational, either polarity.
`timescale 1ns/10ps
`include "pldhk_defines.svh"
module pldhk_top
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [`PLDHK_NUM_IN-1:0] in_pin,
   input wire logic [`PLDHK_NUM_IN-1:0] in_driven,
   input wire logic [`PLDHK_NUM_MC-1:0] io_in,
   input wire logic [`PLDHK_NUM_MC-1:0] io_driven,
   input wire logic [`PLDHK_NUM_MC-1:0] mc_sum,
   input wire logic [`PLDHK_NUM_MC-1:0] mc_oe,
   input wire logic [`PLDHK_NUM_MC-1:0] cfg_registered,
   input wire logic [`PLDHK_NUM_MC-1:0] cfg_active_high,
   input wire logic preload_req,
   input wire logic [`PLDHK_NUM_MC-1:0] preload_mask,
   input wire logic [`PLDHK_NUM_MC-1:0] preload_val,
   input wire logic verify_req,
   input wire logic fuse_prog,
   input wire logic fuse_erase,
   input wire logic sig_wr,
   input wire logic [`PLDHK_SIG_BITS-1:0] sig_wr_data,
   output logic [`PLDHK_NUM_MC-1:0] io_out,
   output logic [`PLDHK_NUM_MC-1:0] io_oe_b,
   output logic [`PLDHK_NUM_MC-1:0] mc_q,
   output logic [`PLDHK_NUM_IN-1:0] in_kept,
   output logic [`PLDHK_NUM_MC-1:0] io_kept,
   output logic clearing,
   output logic secured,
   output logic [`PLDHK_SIG_BITS-1:0] sig_rd,
   output logic [2*`PLDHK_NUM_MC-1:0] verify_data,
   output logic verify_valid,
   output logic verify_refused,
   output logic preload_done,
   output logic preload_refused
);

   localparam logic [`PLDHK_CNT_BITS-1:0] CLEAR_LAST =
      `PLDHK_CNT_BITS'(`PLDHK_CLEAR_CYCLES - 1);

   pldhk_pkg::pldhk_state_t st_q;
   pldhk_pkg::pldhk_state_t st_d;

   // Pin level after the output polarity stage
   function automatic pldhk_pkg::pldhk_mc_t apply_polarity(
      input pldhk_pkg::pldhk_mc_t v,
      input pldhk_pkg::pldhk_mc_t act_high);
      apply_polarity = v ^ ~act_high;
   endfunction

   // Next state
   always_comb
   begin
      pldhk_pkg::pldhk_mc_t comb_v;
      comb_v = '0;
      st_d = st_q;
      st_d.vvalid = 1'b0;
      st_d.vrefused = 1'b0;
      st_d.prefused = 1'b0;
      st_d.pdone = 1'b0;
      // Clear interval holds registers low and ignores clock activity
      if (st_q.phase == pldhk_pkg::PLDHK_CLEARING)
      begin
         st_d.mc = `PLDHK_MC_RESET;
         if (st_q.cnt == CLEAR_LAST)
         begin
            st_d.phase = pldhk_pkg::PLDHK_RUN;
         end
         else
         begin
            st_d.cnt = st_q.cnt + `PLDHK_CNT_BITS'(1);
         end
      end
      else if (preload_req)
      begin
         // Preload wins over the normal clocked load
         if (st_q.fuse)
         begin
            st_d.prefused = 1'b1;
         end
         else
         begin
            st_d.mc = (st_q.mc & ~preload_mask) | (preload_val & preload_mask);
            st_d.pdone = 1'b1;
         end
      end
      else
      begin
         st_d.mc = mc_sum;
      end
      // Registered or combinational macrocell, then polarity
      for (int i = 0; i < `PLDHK_NUM_MC; i++)
      begin
         comb_v[i] = cfg_registered[i] ? st_d.mc[i] : mc_sum[i];
      end
      if (st_q.phase == pldhk_pkg::PLDHK_CLEARING)
      begin
         comb_v = st_d.mc;
      end
      st_d.outv = apply_polarity(comb_v, cfg_active_high);
      st_d.oe_b = (st_q.phase == pldhk_pkg::PLDHK_RUN) ? ~mc_oe : '1;
      // Keepers follow the driven level, hold it otherwise
      for (int i = 0; i < `PLDHK_NUM_IN; i++)
      begin
         st_d.in_keep[i] = in_driven[i] ? in_pin[i] : st_q.in_keep[i];
      end
      for (int i = 0; i < `PLDHK_NUM_MC; i++)
      begin
         if (!st_q.oe_b[i])
         begin
            st_d.io_keep[i] = st_q.outv[i];
         end
         else if (io_driven[i])
         begin
            st_d.io_keep[i] = io_in[i];
         end
      end
      // Pattern verify, blocked once secured
      if (verify_req)
      begin
         if (st_q.fuse)
         begin
            st_d.vrefused = 1'b1;
         end
         else
         begin
            st_d.vdata = {cfg_active_high, cfg_registered};
            st_d.vvalid = 1'b1;
         end
      end
      // Fuse takes effect on the next cycle; programming wins over erase
      if (fuse_prog)
      begin
         st_d.fuse = 1'b1;
      end
      else if (fuse_erase)
      begin
         st_d.fuse = 1'b0;
      end
      // Signature is writable and readable regardless of the fuse
      if (sig_wr)
      begin
         st_d.sig = sig_wr_data;
      end
   end

   // State register, cleared without a clock at power-up
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q <= '0;
         st_q.phase <= pldhk_pkg::PLDHK_CLEARING;
         st_q.mc <= `PLDHK_MC_RESET;
         st_q.oe_b <= '1;
         st_q.sig <= `PLDHK_SIG_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   assign io_out = st_q.outv;
   assign io_oe_b = st_q.oe_b;
   assign mc_q = st_q.mc;
   assign in_kept = st_q.in_keep;
   assign io_kept = st_q.io_keep;
   assign clearing = 1'(st_q.phase); // Phase code is high while clearing
   assign secured = st_q.fuse;
   assign sig_rd = st_q.sig;
   assign verify_data = st_q.vdata;
   assign verify_valid = st_q.vvalid;
   assign verify_refused = st_q.vrefused;
   assign preload_done = st_q.pdone;
   assign preload_refused = st_q.prefused;

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   sequence preload_ok_s;
      preload_req && !secured && !clearing;
   endsequence
   sequence preload_bad_s;
      preload_req && secured && !clearing;
   endsequence

   clear_holds_low_a: assert property (clearing |-> mc_q == '0)
      else $error("register not low during clear");
   clear_ends_a: assert property ($rose(rst_b) |-> clearing [*8])
      else $error("clear interval ended too early");
   clear_bound_a: assert property (clearing |-> ##[1:200] !clearing)
      else $error("clear interval too long");
   polarity_a: assert property ($fell(clearing) |-> io_out == ~cfg_active_high
      || $changed(cfg_active_high) || $past(preload_req))
      else $error("output polarity wrong after clear");
   preload_a: assert property (preload_ok_s |=> preload_done &&
      (mc_q & $past(preload_mask)) == ($past(preload_val) & $past(preload_mask)))
      else $error("preload value not loaded");
   preload_refuse_a: assert property (preload_bad_s |=> preload_refused &&
      !preload_done && mc_q == $past(mc_q))
      else $error("preload not refused when secured");
   verify_refuse_a: assert property (verify_req && secured |=> verify_refused &&
      !verify_valid)
      else $error("verify not refused when secured");
   sig_keep_a: assert property (sig_wr |=> sig_rd == $past(sig_wr_data))
      else $error("signature not stored");
   fuse_now_a: assert property (fuse_prog |=> secured)
      else $error("fuse not effective next cycle");
   keeper_a: assert property (!in_driven[0] |=> in_kept[0] == $past(in_kept[0]))
      else $error("input keeper lost its level");
   comb_cell_a: assert property (!clearing && !cfg_registered[0] && !preload_req |=>
      io_out[0] == ($past(mc_sum[0]) ^ ~$past(cfg_active_high[0])))
      else $error("combinational cell output wrong");

endmodule // pldhk_top

//--- verification/pldhk_prog_model.sv
// Programmer model: one-cycle requests into the housekeeping block
`timescale 1ns/10ps
module pldhk_prog_model
(
   input wire logic clk_sys,
   output logic preload_req,
   output logic verify_req,
   output logic fuse_prog,
   output logic fuse_erase,
   output logic sig_wr,
   output logic [9:0] preload_mask,
   output logic [9:0] preload_val,
   output logic [63:0] sig_wr_data
);
   // Idle lines at time zero
   initial
   begin
      {preload_req, verify_req, fuse_prog, fuse_erase, sig_wr} = 5'h00;
      {preload_mask, preload_val, sig_wr_data} = 84'h0;
   end

   // Request for one cycle, data scrambled once released
   task automatic op(input logic [3:0] k, input logic [9:0] m, input logic [9:0] v,
      input logic [63:0] d);
      @(negedge clk_sys);
      {preload_req, verify_req, fuse_prog, sig_wr} = k;
      {preload_mask, preload_val, sig_wr_data} = {m, v, d};
      @(negedge clk_sys);
      {preload_req, verify_req, fuse_prog, sig_wr} = 4'h0;
      {preload_mask, preload_val, sig_wr_data} = ~{m, v, d};
   endtask

   // Fuse erase request for one cycle
   task automatic erase();
      @(negedge clk_sys);
      fuse_erase = 1'b1;
      @(negedge clk_sys);
      fuse_erase = 1'b0;
   endtask
endmodule // pldhk_prog_model

//--- verification/pldhk_top_tb.sv
// Self-checking bench for the housekeeping block
`timescale 1ns/10ps
module pldhk_top_tb;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [11:0] in_pin = 12'h000, in_driven = 12'h000, in_kept;
   logic [9:0] io_in = 10'h000, io_driven = 10'h000, mc_sum = 10'h3ff, mc_oe = 10'h000;
   logic [9:0] cfg_registered = 10'h000, cfg_active_high = 10'h0f0;
   logic [9:0] io_out, io_oe_b, mc_q, io_kept, preload_mask, preload_val;
   logic [19:0] verify_data;
   logic [63:0] sig_rd, sig_wr_data;
   logic clearing, secured, verify_valid, verify_refused, preload_done, preload_refused;
   logic preload_req, verify_req, fuse_prog, fuse_erase, sig_wr;
   int num_errors = 0;
   int cmp_count = 0;
   int n = 0;

   // 200 MHz clock
   always #2.5 clk_sys = ~clk_sys;

   pldhk_top dut_u (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_pin(in_pin),
      .in_driven(in_driven),
      .io_in(io_in),
      .io_driven(io_driven),
      .mc_sum(mc_sum),
      .mc_oe(mc_oe),
      .cfg_registered(cfg_registered),
      .cfg_active_high(cfg_active_high),
      .preload_req(preload_req),
      .preload_mask(preload_mask),
      .preload_val(preload_val),
      .verify_req(verify_req),
      .fuse_prog(fuse_prog),
      .fuse_erase(fuse_erase),
      .sig_wr(sig_wr),
      .sig_wr_data(sig_wr_data),
      .io_out(io_out),
      .io_oe_b(io_oe_b),
      .mc_q(mc_q),
      .in_kept(in_kept),
      .io_kept(io_kept),
      .clearing(clearing),
      .secured(secured),
      .sig_rd(sig_rd),
      .verify_data(verify_data),
      .verify_valid(verify_valid),
      .verify_refused(verify_refused),
      .preload_done(preload_done),
      .preload_refused(preload_refused)
   );
   pldhk_prog_model prog_u (
      .clk_sys(clk_sys),
      .preload_req(preload_req),
      .verify_req(verify_req),
      .fuse_prog(fuse_prog),
      .fuse_erase(fuse_erase),
      .sig_wr(sig_wr),
      .preload_mask(preload_mask),
      .preload_val(preload_val),
      .sig_wr_data(sig_wr_data)
   );

   // Compare and count
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask

   // Verdict and end of run
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (6) @(negedge clk_sys);
      chk("mc_q", 10'h000, mc_q);
      rst_b = 1'b1;
      @(negedge clk_sys);
      chk("io_out", 10'h30f, io_out);
      chk("io_oe_b", 10'h3ff, io_oe_b);
      while (clearing === 1'b1 && n < 300)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk("clear_edges", 64'd200, 64'(n + 1));
      if (n == 300)
         complete_run();
      chk("mc_q", 10'h000, mc_q);
      $display("test powerup done");
      cfg_registered = 10'h3e0;
      mc_sum = 10'h2a5;
      mc_oe = 10'h0ff;
      @(negedge clk_sys);
      chk("mc_q", 10'h2a5, mc_q);
      chk("io_out", 10'h1aa, io_out);
      chk("io_oe_b", 10'h300, io_oe_b);
      prog_u.op(4'h8, 10'h30f, 10'h155, 64'h0);
      chk("mc_q", 10'h1a5, mc_q);
      chk("preload_done", 1'b1, preload_done);
      prog_u.op(4'h4, 10'h0, 10'h0, 64'h0);
      chk("verify_valid", 1'b1, verify_valid);
      chk("verify_data", 20'h3c3e0, verify_data);
      prog_u.op(4'h1, 10'h0, 10'h0, 64'h0123_4567_89ab_cdef);
      chk("sig_rd", 64'h0123_4567_89ab_cdef, sig_rd);
      $display("test open access done");
      prog_u.op(4'h2, 10'h0, 10'h0, 64'h0);
      chk("secured", 1'b1, secured);
      prog_u.op(4'h8, 10'h3ff, 10'h000, 64'h0);
      chk("preload_refused", 1'b1, preload_refused);
      chk("mc_q", 10'h2a5, mc_q);
      prog_u.op(4'h4, 10'h0, 10'h0, 64'h0);
      chk("verify_refused", 1'b1, verify_refused);
      chk("verify_valid", 1'b0, verify_valid);
      prog_u.op(4'h1, 10'h0, 10'h0, 64'hfedc_ba98_7654_3210);
      chk("sig_rd", 64'hfedc_ba98_7654_3210, sig_rd);
      $display("test secured done");
      prog_u.erase();
      chk("secured", 1'b0, secured);
      $display("test fuse erase done");
      {in_driven, in_pin, io_driven, io_in, mc_oe} = {12'hfff, 12'ha5c, 10'h3ff, 10'h1c3, 10'h0};
      repeat (2) @(negedge clk_sys);
      {in_driven, in_pin, io_driven, io_in} = {12'h000, 12'h5a3, 10'h000, 10'h23c};
      repeat (2) @(negedge clk_sys);
      chk("in_kept", 12'ha5c, in_kept);
      chk("io_kept", 10'h1c3, io_kept);
      $display("test keepers done");
      rst_b = 1'b0;
      #1;
      chk("mc_q", 10'h000, mc_q);
      chk("clearing", 1'b1, clearing);
      $display("test async clear done");
      complete_run();
   end
endmodule // pldhk_top_tb
